// ---- common/clcd_if.sv ----
`timescale 1ns/10ps
`default_nettype none
// Host bus between the microcontroller end and the controller end.
// Each end drives its own set of data lines with its own enable; nothing resolves them into one bus.
interface clcd_if;
    logic [1:0] rs;
    logic       rw;
    logic       e;
    logic [7:0] db_h;
    logic       db_h_oe;
    logic [7:0] db_d;
    logic       db_d_oe;

    modport dev  (input rs, rw, e, db_h, db_h_oe, output db_d, db_d_oe);
    modport host (output rs, rw, e, db_h, db_h_oe, input db_d, db_d_oe);
endinterface
`default_nettype wire

// ---- common/clcd_pkg.sv ----
`default_nettype none
package clcd_pkg;
    // Core clock and power-on initialisation time.
    localparam int          CLK_HZ         = 40_000_000;
    localparam int          INIT_MS        = 15;
    localparam int          INIT_CYCLES    = INIT_MS * (CLK_HZ / 1000);
    localparam int          CNT_W          = 24;

    // Display memory and panel geometry.
    localparam int          AC_W           = 7;
    localparam int          DRAM_DEPTH     = 128;
    localparam int          ROWS           = 16;
    localparam int          COLS           = 100;
    localparam int          COLS_HALF      = 50;
    localparam logic [2:0]  CHAR_LAST_COL  = 3'h4;
    localparam logic [6:0]  OWN_CHARS      = 7'h14;
    localparam logic [6:0]  LAST_CHAR_1L   = 7'h4F;
    localparam logic [6:0]  LAST_CHAR_2L   = 7'h27;
    localparam logic [3:0]  LAST_ROW_5X7   = 4'h7;
    localparam logic [3:0]  LAST_ROW_5X10  = 4'hA;
    localparam logic [3:0]  LAST_ROW_2L    = 4'hF;
    localparam int          BLINK_W        = 6;

    // Register selection on the host bus.
    localparam logic [1:0]  RS_DATA        = 2'h3;
    localparam logic [1:0]  RS_INSTR       = 2'h2;
    localparam logic [1:0]  RS_CONTRAST    = 2'h0;

    // Instruction opcode bits, highest set bit selects the instruction.
    localparam int          INS_SET_DD     = 7;
    localparam int          INS_SET_CG     = 6;
    localparam int          INS_FUNC       = 5;
    localparam int          INS_SHIFT      = 4;
    localparam int          INS_DISP       = 3;
    localparam int          INS_ENTRY      = 2;
    localparam int          INS_HOME       = 1;
    localparam int          INS_CLEAR      = 0;
    localparam int          FUNC_BUS8_BIT  = 4;
    localparam int          FUNC_LINES_BIT = 3;
    localparam int          FUNC_FONT_BIT  = 2;
    localparam int          SHIFT_SC_BIT   = 3;
    localparam int          SHIFT_RL_BIT   = 2;
    localparam int          DISP_ON_BIT    = 2;
    localparam int          DISP_CUR_BIT   = 1;
    localparam int          DISP_BLINK_BIT = 0;
    localparam int          ENTRY_ID_BIT   = 1;
    localparam int          ENTRY_S_BIT    = 0;

    // State after the built-in reset.
    localparam logic        RST_BUS8       = 1'b1;
    localparam logic        RST_LINES2     = 1'b0;
    localparam logic        RST_FONT       = 1'b0;
    localparam logic        RST_INCR       = 1'b1;
    localparam logic        RST_DSHIFT     = 1'b0;
    localparam logic        RST_DISP       = 1'b0;
    localparam logic        RST_CURSOR     = 1'b0;
    localparam logic        RST_BLINK      = 1'b0;
    localparam logic [7:0]  RST_CONTRAST   = 8'h1F;
    localparam logic [7:0]  BLANK_CODE     = 8'h20;

    // Host controller registers on APB.
    localparam logic [11:0] HREG_CTRL      = 12'h000;
    localparam logic [11:0] HREG_CMD       = 12'h004;
    localparam logic [11:0] HREG_STATUS    = 12'h008;
    localparam int          CTRL_BUS8_BIT  = 0;
    localparam int          CMD_DATA_LSB   = 0;
    localparam int          CMD_RW_BIT     = 8;
    localparam int          CMD_RS_LSB     = 9;
    localparam int          STAT_BUSY_BIT  = 0;
    localparam int          STAT_RD_LSB    = 8;
endpackage
`default_nettype wire

// ---- dv/clcd_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module clcd_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [1:0]  rs,
    input wire logic        rw,
    input wire logic        e,
    input wire logic        db_h_oe,
    input wire logic        db_d_oe,
    input wire logic [15:0] row_drive,
    input wire logic        ext_shift_clock,
    input wire logic        ext_latch,
    input wire logic        frame_alt_signal
);
    // Counts extension bits since the last latch, so a row of the wrong length shows at the latch.
    logic [8:0] bits_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bits_r <= 9'h000;
        end else if (ext_latch) begin
            bits_r <= 9'h000;
        end else if (ext_shift_clock) begin
            bits_r <= bits_r + 9'h001;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence latch_once;
        ext_latch ##1 !ext_latch;
    endsequence
    strobe_one_a: assert property (e |=> !e)
        else $error("host strobe longer than one cycle");
    dev_drive_a: assert property (db_d_oe |-> e && rw && !db_h_oe)
        else $error("device drive enable outside read strobe or both ends driving");
    row_onehot_a: assert property (ext_latch |-> $onehot(row_drive))
        else $error("row drive not one-hot at latch");
    host_drive_a: assert property (e && !rw |-> db_h_oe)
        else $error("host not driving during write strobe");
    setup_hold_a: assert property ($rose(e) |-> $stable(rs) && $stable(rw))
        else $error("select changed at strobe");
    latch_pulse_a: assert property (ext_latch |-> latch_once)
        else $error("latch pulse not single cycle");
    latch_follows_a: assert property (ext_latch |-> $past(ext_shift_clock))
        else $error("latch not right after last bit");
    row_bits_a: assert property (ext_latch |-> bits_r == 9'h12C || bits_r == 9'h064)
        else $error("wrong bit count before latch");
    alt_toggle_a: assert property (ext_latch |-> frame_alt_signal != $past(frame_alt_signal))
        else $error("frame signal did not toggle at latch");
    alt_hold_a: assert property (!ext_latch |-> $stable(frame_alt_signal))
        else $error("frame signal moved between latches");
endmodule
`default_nettype wire

// ---- dv/test_char_lcd_host_bus_reset_seg_shift.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_char_lcd_host_bus_reset_seg_shift
    import clcd_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, chk;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, ext_shift_clock, ext_latch, frame_alt_signal;
    logic [1:0]  sel;
    logic [15:0] row_drive;
    logic [32:0] exp_q[$];
    logic [31:0] msk_q[$];
    int          n_fail, total_checks;
    int          seed = 99;

    clcd_if clcd_if_i ();
    clcd_host clcd_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(clcd_if_i));
    clcd_dev #(.INIT_CYC(20)) clcd_dev_i (.pclk(pclk), .presetn(presetn), .bus(clcd_if_i),
        .shift_dir_sel0(sel[0]), .shift_dir_sel1(sel[1]), .row_drive(row_drive), .column_drive(), .ext_data(),
        .ext_shift_clock(ext_shift_clock), .ext_latch(ext_latch), .frame_alt_signal(frame_alt_signal));
    clcd_monitor clcd_monitor_i (.pclk(pclk), .presetn(presetn), .rs(clcd_if_i.rs), .rw(clcd_if_i.rw),
        .e(clcd_if_i.e), .db_h_oe(clcd_if_i.db_h_oe), .db_d_oe(clcd_if_i.db_d_oe), .row_drive(row_drive),
        .ext_shift_clock(ext_shift_clock), .ext_latch(ext_latch), .frame_alt_signal(frame_alt_signal));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic check(input string name, input logic [32:0] seen, input logic [32:0] want);
        total_checks++;
        if (seen !== want) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, want, seen);
        end
    endtask

    task automatic summarize();
        if (n_fail == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // A read with a zero mask is a poll and is not compared.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
                       input logic [32:0] x);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        chk     <= !w && m != 0;
        if (!w && m != 0) begin
            exp_q.push_back(x);
            msk_q.push_back(m);
        end
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && chk) begin
            check("apb_read", {pslverr, prdata & msk_q.pop_front()}, exp_q.pop_front());
        end
    end

    task automatic cmd(input logic [1:0] r, input logic w, input logic [7:0] b);
        apb(1'b1, HREG_CMD, {21'h0, r, w, b}, '0, '0);
        do apb(1'b0, HREG_STATUS, '0, '0, '0); while (prdata[STAT_BUSY_BIT] !== 1'b0);
    endtask

    task automatic dev_ready();
        do cmd(RS_INSTR, 1'b1, 8'h00); while (prdata[STAT_RD_LSB+7] !== 1'b0);
    endtask

    task automatic ac_is(input logic [6:0] a);
        cmd(RS_INSTR, 1'b1, 8'h00);
        apb(1'b0, HREG_STATUS, '0, 32'h0000_FF01, {18'h0_0000, a, 8'h00});
    endtask

    initial begin
        sel = 2'($random(seed));
        {psel, penable, pwrite, chk, presetn} = '0;
        paddr = '0;
        pwdata = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // The select pins are fixed before reset and never touched again.
        cmd(RS_DATA, 1'b0, 8'h41);
        cmd(RS_INSTR, 1'b1, 8'h00);
        apb(1'b0, HREG_STATUS, '0, 32'h0000_8000, 33'h0_0000_8000);
        dev_ready();
        ac_is(7'h00);
        repeat (3) cmd(RS_DATA, 1'b0, 8'($random(seed)));
        ac_is(7'h03);
        cmd(RS_INSTR, 1'b0, 8'h01);
        dev_ready();
        ac_is(7'h00);
        cmd(RS_INSTR, 1'b0, 8'h20);
        apb(1'b1, HREG_CTRL, '0, '0, '0);
        repeat (2) cmd(RS_DATA, 1'b0, 8'($random(seed)));
        ac_is(7'h02);
        cmd(RS_INSTR, 1'b0, 8'h38);
        apb(1'b1, HREG_CTRL, 32'h0000_0001, '0, '0);
        ac_is(7'h02);
        cmd(RS_INSTR, 1'b0, 8'h08);
        cmd(RS_INSTR, 1'b0, 8'h45);
        cmd(RS_DATA, 1'b0, 8'($random(seed)));
        ac_is(7'h06);
        apb(1'b0, HREG_CTRL, '0, 32'h0000_0001, 33'h0_0000_0001);
        apb(1'b0, 12'hFFC, '0, '1, 33'h1_0000_0000);
        repeat (900) @(posedge pclk);
        summarize();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        summarize();
    end
endmodule
`default_nettype wire

// ---- rtl/clcd_dev.sv ----
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Cursor and blink follow the address counter.
// - Host hides cursor during glyph-RAM access.
// - Sixteen row and hundred column drive outputs.
// - Select inputs set column shift direction.
// - Host keeps select inputs fixed while running.
// - Extra characters stream to extension driver serially.
// - Latch pulse after 60 or 20 characters.
// - Frame alternation toggles with the latch pulse.
// - Busy during init; only busy read answered.
// - Busy stays high 15 ms after power-up.
// - Init clears, 8-bit bus, one line, 5x7.
// - Init: increment, no shift, display off.
// - Init loads contrast value 1F.
// - Host initialises by instructions if unsure.
// - 8-bit width: one access per byte.
// - 4-bit width: high nibble, then low.
// - Host always makes the low-nibble access.
// - Nibble pairs form one transfer; misses misalign.
// - Clear blanks display, address counter to zero.
// - Function set picks width, lines, font.
module clcd_dev
    import clcd_pkg::*;
#(
    parameter int INIT_CYC = INIT_CYCLES
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    clcd_if.dev                    bus,
    input  wire logic              shift_dir_sel0,
    input  wire logic              shift_dir_sel1,
    output logic      [ROWS-1:0]   row_drive,
    output logic      [COLS-1:0]   column_drive,
    output logic                   ext_data,
    output logic                   ext_shift_clock,
    output logic                   ext_latch,
    output logic                   frame_alt_signal
);
    typedef enum logic [2:0] {
        ST_INIT  = 3'b001,
        ST_CLEAR = 3'b010,
        ST_RUN   = 3'b100
    } clcd_dst_e_t;

    typedef struct packed {
        clcd_dst_e_t                    st;
        logic [CNT_W-1:0]               cnt;
        logic                           busy_flag;
        logic                           bus8;
        logic                           lines2;
        logic                           font;
        logic                           incr;
        logic                           dshift;
        logic                           disp_on;
        logic                           cur_on;
        logic                           blink_on;
        logic                           ac_cg;
        logic [AC_W-1:0]                ac;
        logic [AC_W-1:0]                disp_ofs;
        logic [7:0]                     contrast;
        logic                           nib_ph;
        logic [3:0]                     nib_hi;
        logic [7:0]                     rd;
        logic [DRAM_DEPTH-1:0][7:0]     display_ram;
        logic [1:0]                     sel_s1;
        logic [1:0]                     sel_s2;
        logic [COLS-1:0]                chain;
        logic [AC_W-1:0]                ci;
        logic [2:0]                     cc;
        logic [3:0]                     row;
        logic [BLINK_W-1:0]             blink_cnt;
        logic [COLS-1:0]                col_out;
        logic [ROWS-1:0]                row_out;
        logic                           ext_d;
        logic                           ext_ck;
        logic                           ext_l;
        logic                           df;
        logic                           lat_p;
        logic                           scan_l2;
    } clcd_dev_t;

    clcd_dev_t       s_r;
    clcd_dev_t       s_nxt;
    logic            acc;
    logic            full;
    logic [7:0]      byte_v;
    logic [7:0]      rval;
    logic [AC_W-1:0] addr;
    logic [AC_W-1:0] last_ci;
    logic [3:0]      last_row;
    logic [3:0]      cur_row;
    logic [3:0]      rchar;
    logic [7:0]      code;
    logic            pbit;
    logic            is_cur;

    function automatic logic [AC_W-1:0] step(input logic [AC_W-1:0] a, input logic up);
        return up ? a + 7'h01 : a - 7'h01;
    endfunction

    // Maps the serial chain onto the column outputs for each select setting.
    function automatic logic [COLS-1:0] seg_map(input logic [COLS-1:0] ch, input logic [1:0] sel);
        logic [COLS-1:0] m;
        m = '0;
        for (int i = 0; i < COLS; i++) begin
            case (sel)
                2'b00:   m[i] = ch[i];
                2'b10:   m[i] = (i < COLS_HALF) ? ch[i] : ch[COLS + COLS_HALF - 1 - i];
                default: m[i] = ch[COLS - 1 - i];
            endcase
        end
        return m;
    endfunction

    assign bus.db_d         = s_r.rd;
    assign bus.db_d_oe      = bus.e & bus.rw;
    assign row_drive        = s_r.row_out;
    assign column_drive     = s_r.col_out;
    assign ext_data         = s_r.ext_d;
    assign ext_shift_clock  = s_r.ext_ck;
    assign ext_latch        = s_r.ext_l;
    assign frame_alt_signal = s_r.df;

    always_comb begin
        s_nxt = s_r;
        full  = 1'b0;
        byte_v = bus.db_h;
        // Select pins are outside the clock domain and only read after two stages.
        s_nxt.sel_s1 = {shift_dir_sel0, shift_dir_sel1};
        s_nxt.sel_s2 = s_r.sel_s1;

        // While busy only the busy-flag read is taken, so nibble phase holds too.
        acc = bus.e & (~s_r.busy_flag | ((bus.rs == RS_INSTR) & bus.rw));
        if (acc) begin
            if (s_r.bus8) begin
                full = 1'b1;
            end else if (!s_r.nib_ph) begin
                s_nxt.nib_ph = 1'b1;
                s_nxt.nib_hi = bus.db_h[7:4];
            end else begin
                s_nxt.nib_ph = 1'b0;
                full         = 1'b1;
                byte_v       = {s_r.nib_hi, bus.db_h[7:4]};
            end
        end

        rval = (bus.rs == RS_INSTR) ? {s_r.busy_flag, s_r.ac} : s_r.display_ram[s_r.ac];
        if (s_nxt.bus8) s_nxt.rd = rval;
        else            s_nxt.rd = s_nxt.nib_ph ? {rval[3:0], 4'h0} : {rval[7:4], 4'h0};

        if (full & bus.rw & (bus.rs == RS_DATA) & ~s_r.busy_flag) begin
            s_nxt.ac = step(s_r.ac, s_r.incr);
        end else if (full & ~bus.rw & ~s_r.busy_flag) begin
            case (bus.rs)
                RS_DATA: begin
                    // Glyph patterns are not stored here; the address still advances.
                    if (!s_r.ac_cg) s_nxt.display_ram[s_r.ac] = byte_v;
                    s_nxt.ac = step(s_r.ac, s_r.incr);
                    if (s_r.dshift & ~s_r.ac_cg) s_nxt.disp_ofs = step(s_r.disp_ofs, ~s_r.incr);
                end
                RS_CONTRAST: s_nxt.contrast = byte_v;
                RS_INSTR: begin
                    if (byte_v[INS_SET_DD]) begin
                        s_nxt.ac    = byte_v[AC_W-1:0];
                        s_nxt.ac_cg = 1'b0;
                    end else if (byte_v[INS_SET_CG]) begin
                        s_nxt.ac    = {1'b0, byte_v[5:0]};
                        s_nxt.ac_cg = 1'b1;
                    end else if (byte_v[INS_FUNC]) begin
                        s_nxt.bus8   = byte_v[FUNC_BUS8_BIT];
                        s_nxt.lines2 = byte_v[FUNC_LINES_BIT];
                        s_nxt.font   = byte_v[FUNC_FONT_BIT];
                        if (byte_v[FUNC_BUS8_BIT] != s_r.bus8) s_nxt.nib_ph = 1'b0;
                    end else if (byte_v[INS_SHIFT]) begin
                        if (byte_v[SHIFT_SC_BIT]) s_nxt.disp_ofs = step(s_r.disp_ofs, ~byte_v[SHIFT_RL_BIT]);
                        else                      s_nxt.ac = step(s_r.ac, byte_v[SHIFT_RL_BIT]);
                    end else if (byte_v[INS_DISP]) begin
                        s_nxt.disp_on  = byte_v[DISP_ON_BIT];
                        s_nxt.cur_on   = byte_v[DISP_CUR_BIT];
                        s_nxt.blink_on = byte_v[DISP_BLINK_BIT];
                    end else if (byte_v[INS_ENTRY]) begin
                        s_nxt.incr   = byte_v[ENTRY_ID_BIT];
                        s_nxt.dshift = byte_v[ENTRY_S_BIT];
                    end else if (byte_v[INS_HOME]) begin
                        s_nxt.ac       = '0;
                        s_nxt.ac_cg    = 1'b0;
                        s_nxt.disp_ofs = '0;
                    end else if (byte_v[INS_CLEAR]) begin
                        s_nxt.st        = ST_CLEAR;
                        s_nxt.busy_flag = 1'b1;
                        s_nxt.cnt       = '0;
                        s_nxt.incr      = RST_INCR;
                    end
                end
                default: s_nxt.rd = s_nxt.rd;
            endcase
        end

        case (s_r.st)
            ST_INIT: begin
                s_nxt.busy_flag = 1'b1;
                s_nxt.cnt       = s_r.cnt + 24'h00_0001;
                if (s_r.cnt == CNT_W'(INIT_CYC - 1)) begin
                    s_nxt.cnt = '0;
                    s_nxt.st  = ST_CLEAR;
                end
            end
            ST_CLEAR: begin
                s_nxt.display_ram[s_r.cnt[AC_W-1:0]] = BLANK_CODE;
                s_nxt.cnt = s_r.cnt + 24'h00_0001;
                if (s_r.cnt[AC_W-1:0] == AC_W'(DRAM_DEPTH - 1)) begin
                    s_nxt.cnt       = '0;
                    s_nxt.ac        = '0;
                    s_nxt.ac_cg     = 1'b0;
                    s_nxt.disp_ofs  = '0;
                    s_nxt.busy_flag = 1'b0;
                    s_nxt.st        = ST_RUN;
                end
            end
            ST_RUN:  s_nxt.cnt = '0;
            default: s_nxt.st = ST_INIT;
        endcase

        // Row scan: one pattern bit per clock, own columns first, then the extension.
        last_ci  = s_r.scan_l2 ? LAST_CHAR_2L : LAST_CHAR_1L;
        last_row = s_r.lines2 ? LAST_ROW_2L : (s_r.font ? LAST_ROW_5X10 : LAST_ROW_5X7);
        cur_row  = (s_r.font & ~s_r.lines2) ? LAST_ROW_5X10 : LAST_ROW_5X7;
        rchar    = s_r.lines2 ? {1'b0, s_r.row[2:0]} : s_r.row;
        addr     = s_r.lines2 ? {s_r.row[3], 6'(s_r.ci[5:0] + s_r.disp_ofs[5:0])}
                              : AC_W'(s_r.ci + s_r.disp_ofs);
        code     = s_r.display_ram[addr];
        // The cursor follows the counter even when it holds a glyph address.
        is_cur   = (addr == s_r.ac);
        pbit     = code[3'(s_r.cc + rchar[2:0])];
        if (s_r.cur_on & is_cur & (rchar == cur_row)) pbit = 1'b1;
        if (s_r.blink_on & is_cur & s_r.blink_cnt[BLINK_W-1]) pbit = 1'b1;
        pbit = pbit & s_r.disp_on;

        // The latch trails the last shift clock by one cycle, so the final bit is in before the capture.
        s_nxt.lat_p  = 1'b0;
        s_nxt.ext_l  = s_r.lat_p;
        s_nxt.df     = s_r.df ^ s_r.lat_p;
        s_nxt.ext_ck = 1'b0;
        if (s_r.ci < OWN_CHARS) begin
            s_nxt.chain = {s_r.chain[COLS-2:0], pbit};
        end else begin
            s_nxt.ext_d  = pbit;
            s_nxt.ext_ck = 1'b1;
        end
        if ((s_r.ci == last_ci) & (s_r.cc == CHAR_LAST_COL)) begin
            s_nxt.ci      = '0;
            s_nxt.cc      = '0;
            s_nxt.lat_p   = 1'b1;
            // A line-mode change waits for the row end, so no row is cut short.
            s_nxt.scan_l2 = s_r.lines2;
            s_nxt.col_out = seg_map(s_r.chain, s_r.sel_s2);
            s_nxt.row_out = ROWS'(1) << s_r.row;
            if (s_r.row >= last_row) begin
                s_nxt.row       = '0;
                s_nxt.blink_cnt = s_r.blink_cnt + 6'h01;
            end else begin
                s_nxt.row = s_r.row + 4'h1;
            end
        end else if (s_r.cc == CHAR_LAST_COL) begin
            s_nxt.cc = '0;
            s_nxt.ci = s_r.ci + 7'h01;
        end else begin
            s_nxt.cc = s_r.cc + 3'h1;
        end
    end

    // Power-on state is held in constants; the reset doubles as the supply-valid point.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r           <= '0;
            s_r.st        <= ST_INIT;
            s_r.busy_flag <= 1'b1;
            s_r.bus8      <= RST_BUS8;
            s_r.lines2    <= RST_LINES2;
            s_r.font      <= RST_FONT;
            s_r.incr      <= RST_INCR;
            s_r.dshift    <= RST_DSHIFT;
            s_r.disp_on   <= RST_DISP;
            s_r.cur_on    <= RST_CURSOR;
            s_r.blink_on  <= RST_BLINK;
            s_r.contrast  <= RST_CONTRAST;
            s_r.nib_ph    <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/clcd_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module clcd_host
    import clcd_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    clcd_if.host             bus
);
    typedef enum logic [2:0] {
        H_IDLE   = 3'b001,
        H_SETUP  = 3'b010,
        H_STROBE = 3'b100
    } clcd_hst_e_t;

    typedef struct packed {
        clcd_hst_e_t st;
        logic        bus8;
        logic [1:0]  rs;
        logic        rw;
        logic [7:0]  wbyte;
        logic        second;
        logic        e;
        logic [7:0]  db_o;
        logic        db_oe;
        logic [7:0]  rbyte;
        logic [31:0] prdata;
    } clcd_hst_t;

    clcd_hst_t s_r;
    clcd_hst_t s_nxt;
    logic      wr_acc;
    logic      mapped;

    assign pready  = psel & penable;
    assign mapped  = (paddr == HREG_CTRL) | (paddr == HREG_CMD) | (paddr == HREG_STATUS);
    assign pslverr = pready & ~mapped;
    assign wr_acc  = pready & pwrite;
    assign prdata  = s_r.prdata;
    assign bus.rs      = s_r.rs;
    assign bus.rw      = s_r.rw;
    assign bus.e       = s_r.e;
    assign bus.db_h    = s_r.db_o;
    assign bus.db_h_oe = s_r.db_oe;

    always_comb begin
        s_nxt = s_r;
        // Read data is prepared in the setup cycle so it comes from a flip-flop.
        if (psel & ~penable) begin
            s_nxt.prdata = '0;
            case (paddr)
                HREG_CTRL: s_nxt.prdata[CTRL_BUS8_BIT] = s_r.bus8;
                HREG_CMD: begin
                    s_nxt.prdata[CMD_DATA_LSB +: 8] = s_r.wbyte;
                    s_nxt.prdata[CMD_RW_BIT]        = s_r.rw;
                    s_nxt.prdata[CMD_RS_LSB +: 2]   = s_r.rs;
                end
                HREG_STATUS: begin
                    s_nxt.prdata[STAT_BUSY_BIT]    = (s_r.st != H_IDLE);
                    s_nxt.prdata[STAT_RD_LSB +: 8] = s_r.rbyte;
                end
                default: s_nxt.prdata = '0;
            endcase
        end
        if (wr_acc & (paddr == HREG_CTRL)) begin
            s_nxt.bus8 = pwdata[CTRL_BUS8_BIT];
        end
        case (s_r.st)
            H_IDLE: begin
                s_nxt.e     = 1'b0;
                s_nxt.db_oe = 1'b0;
                // A command written while a transfer runs is dropped.
                if (wr_acc & (paddr == HREG_CMD)) begin
                    s_nxt.wbyte  = pwdata[CMD_DATA_LSB +: 8];
                    s_nxt.rw     = pwdata[CMD_RW_BIT];
                    s_nxt.rs     = pwdata[CMD_RS_LSB +: 2];
                    s_nxt.second = 1'b0;
                    s_nxt.db_oe  = ~pwdata[CMD_RW_BIT];
                    s_nxt.db_o   = pwdata[CMD_DATA_LSB +: 8];
                    s_nxt.st     = H_SETUP;
                end
            end
            H_SETUP: begin
                s_nxt.e  = 1'b1;
                s_nxt.st = H_STROBE;
            end
            H_STROBE: begin
                s_nxt.e = 1'b0;
                if (s_r.bus8) begin
                    if (s_r.rw) s_nxt.rbyte = bus.db_d;
                    s_nxt.db_oe = 1'b0;
                    s_nxt.st    = H_IDLE;
                end else if (!s_r.second) begin
                    // The low nibble always follows, even after a busy read.
                    if (s_r.rw) s_nxt.rbyte[7:4] = bus.db_d[7:4];
                    s_nxt.db_o   = {s_r.wbyte[3:0], 4'h0};
                    s_nxt.second = 1'b1;
                    s_nxt.st     = H_SETUP;
                end else begin
                    if (s_r.rw) s_nxt.rbyte[3:0] = bus.db_d[7:4];
                    s_nxt.db_oe = 1'b0;
                    s_nxt.st    = H_IDLE;
                end
            end
            default: s_nxt.st = H_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r        <= '0;
            s_r.st     <= H_IDLE;
            s_r.bus8   <= RST_BUS8;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule
`default_nettype wire
